/* logic/spao_pkg.sv */
// package for the setpoint alarm output logic
package spao_pkg;
  localparam int SPAO_NUM_SP = 2;
  localparam int SPAO_VAL_W = 18;
  localparam logic signed [17:0] SPAO_SP_MIN = -18'sd19999;
  localparam logic signed [17:0] SPAO_SP_MAX = 18'sd99999;
  localparam logic [15:0] SPAO_HYS_MIN = 16'h0001;
  localparam logic [15:0] SPAO_HYS_MAX = 16'hEA5F;
  localparam logic [12:0] SPAO_ON_DLY_MAX = 13'h03E7;
  localparam logic [12:0] SPAO_OFF_DLY_MAX = 13'h176F;
  localparam int SPAO_CLK_HZ = 100000000;
  localparam int SPAO_SEC_S = 1;
  localparam int SPAO_SEC_CYCLES = SPAO_SEC_S * SPAO_CLK_HZ;
  localparam logic [31:0] SPAO_BUS_OKAY = 32'h0000_0000;
  // register byte addresses
  localparam logic [7:0] SPAO_CTRL_OFF = 8'h00;
  localparam logic [7:0] SPAO_STAT_OFF = 8'h04;
  localparam logic [7:0] SPAO_SP0_OFF = 8'h10;
  localparam logic [7:0] SPAO_HYS0_OFF = 8'h14;
  localparam logic [7:0] SPAO_DLY0_OFF = 8'h18;
  localparam logic [7:0] SPAO_CFG0_OFF = 8'h1C;
  localparam logic [7:0] SPAO_CH_STRIDE = 8'h10;
  // ctrl bits
  localparam int SPAO_CTRL_SP2EN = 0;
  localparam int SPAO_CTRL_SERRST0 = 1;
  localparam int SPAO_CTRL_SERRST1 = 2;
  // cfg field positions
  localparam int SPAO_CFG_ACT_LSB = 0;
  localparam int SPAO_CFG_RST_LSB = 2;
  localparam int SPAO_CFG_DSPRST = 4;
  localparam int SPAO_CFG_STBY = 5;
  localparam int SPAO_CFG_CCHG = 6;
  localparam int SPAO_CFG_FRONT_DSP = 7;
  localparam int SPAO_CFG_USER_DSP = 8;
  localparam logic [15:0] SPAO_HYS_RST = 16'h0001;
  typedef enum logic [1:0] {
    high_acting_balanced = 2'b00,
    low_acting_balanced = 2'b01,
    high_acting_unbalanced = 2'b10,
    low_acting_unbalanced = 2'b11
  } spao_act_t;
  typedef enum logic [1:0] {
    auto_clear_mode = 2'b00,
    latch_immediate_clear_mode = 2'b01,
    latch_deferred_clear_mode = 2'b10
  } spao_rst_t;
  typedef struct packed {
    logic color_chg;
    logic standby;
    logic dsp_rst;
    spao_rst_t rst_mode;
    spao_act_t act;
  } spao_cfg_t;
  typedef enum logic [1:0] {
    st_off = 2'b00,
    st_on_wait = 2'b01,
    st_on = 2'b10,
    st_off_wait = 2'b11
  } spao_st_t;
endpackage

/* logic/spao_top.sv */
// setpoint alarm output logic with ahb-lite register slave
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
module spao_top
  import spao_pkg::*;
#(
  parameter int SEC_CYCLES = SPAO_SEC_CYCLES // cycles per second
)(
  input wire logic clk, // 100 mhz clock
  input wire logic resetn, // async reset, low
  input wire logic hsel, // ahb select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb ready in
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb ready out
  output logic hresp, // ahb response
  input wire logic signed [17:0] disp_val, // displayed value
  input wire logic input_shown, // input value on display
  input wire logic card_present, // output card pin
  input wire logic [1:0] card_outputs, // usable outputs pin
  input wire logic backlit, // backlight unit pin
  input wire logic front_rst_pin, // front reset button
  input wire logic user_rst_pin, // user input reset
  output logic [1:0] sp_out, // setpoint outputs
  output logic [1:0] color_green // backlight colour per output
);
  logic [2:1] card_s1_ff, card_s2_ff;
  logic [1:0] outs_s1_ff, outs_s2_ff;
  logic [1:0] rst_s1_ff, rst_s2_ff, rst_d_ff;
  logic bl_s1_ff, bl_s2_ff;
  logic front_pulse, user_pulse;
  logic sp2_en_ff;
  logic [1:0] serial_rst_ff;
  logic signed [17:0] sp_ff [2];
  logic [15:0] hys_ff [2];
  logic [12:0] on_dly_ff [2];
  logic [12:0] off_dly_ff [2];
  spao_cfg_t cfg_ff [2];
  logic [1:0] front_dsp_ff, user_dsp_ff;
  logic addr_ph_ff, wr_ph_ff;
  logic [7:0] addr_ff;
  logic pup_ff;
  logic [1:0] chan_en;
  logic [1:0] out_state;

  // pin synchronisers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      card_s1_ff <= 2'h0;
      card_s2_ff <= 2'h0;
      outs_s1_ff <= 2'h0;
      outs_s2_ff <= 2'h0;
      rst_s1_ff <= 2'h0;
      rst_s2_ff <= 2'h0;
      rst_d_ff <= 2'h0;
      bl_s1_ff <= 1'b0;
      bl_s2_ff <= 1'b0;
    end
    else
    begin
      card_s1_ff <= {input_shown, card_present};
      card_s2_ff <= card_s1_ff;
      outs_s1_ff <= card_outputs;
      outs_s2_ff <= outs_s1_ff;
      rst_s1_ff <= {user_rst_pin, front_rst_pin};
      rst_s2_ff <= rst_s1_ff;
      rst_d_ff <= rst_s2_ff;
      bl_s1_ff <= backlit;
      bl_s2_ff <= bl_s1_ff;
    end
  end
  // momentary presses become one-cycle pulses
  assign front_pulse = rst_s2_ff[0] & ~rst_d_ff[0];
  assign user_pulse = rst_s2_ff[1] & ~rst_d_ff[1];

  // power-up marker, cleared after first evaluation
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pup_ff <= 1'b1;
    else
      pup_ff <= 1'b0;
  end

  // channel enable from card, count and sp2 enable
  assign chan_en[0] = card_s2_ff[1] & (outs_s2_ff != 2'h0);
  assign chan_en[1] = card_s2_ff[1] & (outs_s2_ff >= 2'h2) & sp2_en_ff;

  // ahb-lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp = SPAO_BUS_OKAY[0];
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_ph_ff <= 1'b0;
      wr_ph_ff <= 1'b0;
      addr_ff <= 8'h00;
    end
    else if (hready)
    begin
      addr_ph_ff <= hsel & htrans[1];
      wr_ph_ff <= hsel & htrans[1] & hwrite;
      addr_ff <= {haddr[7:2], 2'b00};
    end
  end

  function automatic logic ch_hit(input logic [7:0] a, input logic [7:0] base, input int ch);
    ch_hit = (a == 8'(base + 8'(ch * 16)));
  endfunction

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sp2_en_ff <= 1'b0;
      serial_rst_ff <= 2'h0;
      for (int i = 0; i < 2; i++)
      begin
        sp_ff[i] <= 18'sh0_0000;
        hys_ff[i] <= SPAO_HYS_RST;
        on_dly_ff[i] <= 13'h0000;
        off_dly_ff[i] <= 13'h0000;
        cfg_ff[i] <= '0;
        front_dsp_ff[i] <= 1'b0;
        user_dsp_ff[i] <= 1'b0;
      end
    end
    else
    begin
      serial_rst_ff <= 2'h0;
      if (wr_ph_ff)
      begin
        if (addr_ff == SPAO_CTRL_OFF)
        begin
          sp2_en_ff <= hwdata[SPAO_CTRL_SP2EN];
          serial_rst_ff <= {hwdata[SPAO_CTRL_SERRST1], hwdata[SPAO_CTRL_SERRST0]};
        end
        for (int i = 0; i < 2; i++)
        begin
          if (ch_hit(addr_ff, SPAO_SP0_OFF, i))
          begin
            // clamp threshold to displayable range
            if ($signed(hwdata[17:0]) < SPAO_SP_MIN)
              sp_ff[i] <= SPAO_SP_MIN;
            else if ($signed(hwdata[17:0]) > SPAO_SP_MAX)
              sp_ff[i] <= SPAO_SP_MAX;
            else
              sp_ff[i] <= $signed(hwdata[17:0]);
          end
          if (ch_hit(addr_ff, SPAO_HYS0_OFF, i))
          begin
            if (hwdata[15:0] < SPAO_HYS_MIN)
              hys_ff[i] <= SPAO_HYS_MIN;
            else if (hwdata[15:0] > SPAO_HYS_MAX)
              hys_ff[i] <= SPAO_HYS_MAX;
            else
              hys_ff[i] <= hwdata[15:0];
          end
          if (ch_hit(addr_ff, SPAO_DLY0_OFF, i))
          begin
            on_dly_ff[i] <= (hwdata[12:0] > SPAO_ON_DLY_MAX) ? SPAO_ON_DLY_MAX : hwdata[12:0];
            off_dly_ff[i] <= (hwdata[28:16] > SPAO_OFF_DLY_MAX) ? SPAO_OFF_DLY_MAX : hwdata[28:16];
          end
          if (ch_hit(addr_ff, SPAO_CFG0_OFF, i))
          begin
            cfg_ff[i] <= spao_cfg_t'(hwdata[6:0]);
            front_dsp_ff[i] <= hwdata[SPAO_CFG_FRONT_DSP];
            user_dsp_ff[i] <= hwdata[SPAO_CFG_USER_DSP];
          end
        end
      end
    end
  end

  // read mux
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (addr_ph_ff)
    begin
      if (addr_ff == SPAO_CTRL_OFF)
        hrdata = {31'h0000_0000, sp2_en_ff};
      else if (addr_ff == SPAO_STAT_OFF)
        hrdata = {26'h000_0000, color_green, chan_en, out_state};
      for (int i = 0; i < 2; i++)
      begin
        if (ch_hit(addr_ff, SPAO_SP0_OFF, i))
          hrdata = {{14{sp_ff[i][17]}}, sp_ff[i]};
        else if (ch_hit(addr_ff, SPAO_HYS0_OFF, i))
          hrdata = {16'h0000, hys_ff[i]};
        else if (ch_hit(addr_ff, SPAO_DLY0_OFF, i))
          hrdata = {3'h0, off_dly_ff[i], 3'h0, on_dly_ff[i]};
        else if (ch_hit(addr_ff, SPAO_CFG0_OFF, i))
          hrdata = {23'h00_0000, user_dsp_ff[i], front_dsp_ff[i], cfg_ff[i]};
      end
    end
  end

  // per-channel comparator, timers and reset logic
  logic [26:0] presc_ff [2];
  logic [12:0] sec_ff [2];
  spao_st_t st_ff [2];
  logic [1:0] standby_ff, pend_ff, blk_ff, green_ff, out_d_ff;
  logic [1:0] on_cond, off_cond, rst_req;

  function automatic logic signed [18:0] half(input logic [15:0] h);
    half = $signed({4'b0000, h[15:1]});
  endfunction

  for (genvar g = 0; g < 2; g++)
  begin : g_ch
    logic signed [18:0] v, s, h, on_pt, off_pt, band;
    logic hi_act, bal, tick, dly_done;
    logic [12:0] dly;
    assign v = 19'(disp_val);
    assign s = 19'(sp_ff[g]);
    assign h = $signed({3'b000, hys_ff[g]});
    assign hi_act = (cfg_ff[g].act == high_acting_balanced) | (cfg_ff[g].act == high_acting_unbalanced);
    assign bal = (cfg_ff[g].act == high_acting_balanced) | (cfg_ff[g].act == low_acting_balanced);
    // balanced splits the band about the setpoint, unbalanced puts it all on the release side
    assign band = bal ? half(hys_ff[g]) : h;
    assign on_pt = !bal ? s : (hi_act ? 19'(s + band) : 19'(s - band));
    assign off_pt = hi_act ? 19'(s - band) : 19'(s + band);
    assign on_cond[g] = hi_act ? (v >= on_pt) : (v <= on_pt);
    assign off_cond[g] = hi_act ? (v <= off_pt) : (v >= off_pt);
    // front and user presses reset on their own; the display-linked term also needs option, source assigned and input shown
    assign rst_req[g] = serial_rst_ff[g] | front_pulse | user_pulse
      | (cfg_ff[g].dsp_rst & card_s2_ff[2] & ((front_pulse & front_dsp_ff[g]) | (user_pulse & user_dsp_ff[g])));
    assign tick = (presc_ff[g] == 27'(SEC_CYCLES - 1));
    assign dly = (st_ff[g] == st_on_wait) ? on_dly_ff[g] : off_dly_ff[g];
    assign dly_done = (dly == 13'h0000) | (tick & (sec_ff[g] == 13'(dly - 13'h0001)));
    assign out_state[g] = (st_ff[g] == st_on) | (st_ff[g] == st_off_wait);

    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        presc_ff[g] <= 27'h000_0000;
        sec_ff[g] <= 13'h0000;
      end
      else if ((st_ff[g] == st_on_wait) || (st_ff[g] == st_off_wait))
      begin
        presc_ff[g] <= tick ? 27'h000_0000 : 27'(presc_ff[g] + 27'h000_0001);
        sec_ff[g] <= tick ? 13'(sec_ff[g] + 13'h0001) : sec_ff[g];
      end
      else
      begin
        presc_ff[g] <= 27'h000_0000;
        sec_ff[g] <= 13'h0000;
      end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        st_ff[g] <= st_off;
        standby_ff[g] <= 1'b1;
        pend_ff[g] <= 1'b0;
        blk_ff[g] <= 1'b0;
      end
      else if (!chan_en[g])
      begin
        st_ff[g] <= st_off;
        pend_ff[g] <= 1'b0;
        blk_ff[g] <= 1'b0;
      end
      else
      begin
        if (pup_ff && rst_s2_ff != 2'h0 && cfg_ff[g].rst_mode == latch_deferred_clear_mode)
          pend_ff[g] <= 1'b1;
        if (!on_cond[g])
          blk_ff[g] <= 1'b0;
        if (!on_cond[g])
          standby_ff[g] <= 1'b0;
        unique case (st_ff[g])
          st_off:
            if (on_cond[g] && !blk_ff[g] && !(cfg_ff[g].standby && standby_ff[g]))
              st_ff[g] <= st_on_wait;
          st_on_wait:
            if (!on_cond[g])
              st_ff[g] <= st_off;
            else if (dly_done)
              st_ff[g] <= st_on;
          st_on:
            if (rst_req[g] && cfg_ff[g].rst_mode != latch_deferred_clear_mode)
            begin
              st_ff[g] <= st_off;
              blk_ff[g] <= 1'b1;
            end
            else if (rst_req[g])
              pend_ff[g] <= 1'b1;
            else if (off_cond[g] && (cfg_ff[g].rst_mode == auto_clear_mode || pend_ff[g]))
              st_ff[g] <= st_off_wait;
          st_off_wait:
            if (rst_req[g] && cfg_ff[g].rst_mode != latch_deferred_clear_mode)
            begin
              st_ff[g] <= st_off;
              blk_ff[g] <= 1'b1;
            end
            else if (!off_cond[g])
              st_ff[g] <= st_on;
            else if (dly_done)
            begin
              st_ff[g] <= st_off;
              pend_ff[g] <= 1'b0;
            end
        endcase
      end
    end

    chk_on_needs_trig: assert property (@(posedge clk) disable iff (!resetn)
      ($past(st_ff[g]) == st_off && st_ff[g] == st_on_wait) |-> $past(on_cond[g])) else $error("on without trigger");
    chk_disabled_off: assert property (@(posedge clk) disable iff (!resetn)
      !chan_en[g] |=> !out_state[g]) else $error("disabled output on");
    chk_latch_holds: assert property (@(posedge clk) disable iff (!resetn)
      (st_ff[g] == st_on && cfg_ff[g].rst_mode == latch_immediate_clear_mode && !rst_req[g] && chan_en[g])
      |=> out_state[g]) else $error("latch dropped");
    chk_imm_clear: assert property (@(posedge clk) disable iff (!resetn)
      (st_ff[g] == st_on && rst_req[g] && cfg_ff[g].rst_mode == latch_immediate_clear_mode) |=> st_ff[g] == st_off)
      else $error("immediate clear missed");
    chk_defer_hold: assert property (@(posedge clk) disable iff (!resetn)
      (st_ff[g] == st_on && rst_req[g] && chan_en[g] && cfg_ff[g].rst_mode == latch_deferred_clear_mode)
      |=> out_state[g] && pend_ff[g]) else $error("deferred clear early");
    chk_wait_restart: assert property (@(posedge clk) disable iff (!resetn)
      (st_ff[g] == st_on_wait && !on_cond[g]) |=> st_ff[g] == st_off) else $error("on wait kept");
    chk_zero_delay: assert property (@(posedge clk) disable iff (!resetn)
      (st_ff[g] == st_on_wait && on_cond[g] && on_dly_ff[g] == 13'h0000 && chan_en[g]) |=> st_ff[g] == st_on)
      else $error("zero on delay slow");
  end

  // colour flips on every output change of backlit units
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_d_ff <= 2'h0;
      green_ff <= 2'h0;
    end
    else
    begin
      out_d_ff <= out_state;
      for (int i = 0; i < 2; i++)
        if (bl_s2_ff && cfg_ff[i].color_chg && out_state[i] != out_d_ff[i])
          green_ff[i] <= ~green_ff[i];
    end
  end
  assign color_green = green_ff;
  assign sp_out = out_state;

  chk_color_flip: assert property (@(posedge clk) disable iff (!resetn)
    (bl_s2_ff && cfg_ff[0].color_chg && $changed(out_state[0])) |=> $changed(green_ff[0]))
    else $error("colour not toggled");
  chk_no_card: assert property (@(posedge clk) disable iff (!resetn)
    !card_s2_ff[1] [*2] |-> !sp_out[0]) else $error("output without card");
endmodule

/* tb/spao_card_model.sv */
// behavioural model of the setpoint output card and its loads
module spao_card_model
  import spao_pkg::*;
(
  input wire logic fitted, // card plugged in
  input wire logic [1:0] usable, // outputs wired on the card
  output logic card_present, // presence pin
  output logic [1:0] card_outputs, // usable-count pin
  input wire logic [1:0] sp_out, // setpoint outputs
  output logic [1:0] load_on // loads energised
);
  timeunit 1ns;
  timeprecision 1ps;
  assign card_present = fitted;
  assign card_outputs = fitted ? usable : 2'b00;
  // an unwired or absent output drives no load
  assign load_on[0] = fitted & sp_out[0] & (usable != 2'd0);
  assign load_on[1] = fitted & sp_out[1] & (usable == 2'd2);
endmodule

/* tb/spao_top_bench.sv */
// self-checking bench for the setpoint alarm output logic
module spao_top_bench
  import spao_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic signed [17:0] disp_val = 18'sd50;
  logic input_shown = 1'b1;
  logic fitted = 1'b1;
  logic [1:0] usable = 2'd2;
  logic backlit = 1'b1;
  logic front_rst_pin = 1'b0;
  logic user_rst_pin = 1'b0;
  logic [31:0] hrdata;
  logic hready, hreadyout, hresp, card_present, c0;
  logic [1:0] sp_out, color_green, card_outputs, load_on;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int vals [4][5] = '{'{50, 105, 115, 95, 85}, '{50, 90, 101, 85, 75}, '{150, 95, 85, 105, 115},
    '{150, 110, 99, 115, 125}};
  logic [1:0] acts [4] = '{high_acting_balanced, high_acting_unbalanced, low_acting_balanced,
    low_acting_unbalanced};
  logic exps [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  assign hready = hreadyout;
  spao_top #(.SEC_CYCLES(10)) dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .disp_val(disp_val), .input_shown(input_shown), .card_present(card_present),
    .card_outputs(card_outputs), .backlit(backlit), .front_rst_pin(front_rst_pin),
    .user_rst_pin(user_rst_pin), .sp_out(sp_out), .color_green(color_green));
  spao_card_model card (.fitted(fitted), .usable(usable), .card_present(card_present),
    .card_outputs(card_outputs), .sp_out(sp_out), .load_on(load_on));
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
      begin
        fails++;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    check(x, exp);
    check({31'h0, hresp}, 32'h0000_0000);
  endtask
  task automatic outchk(input int n, input logic [1:0] exp);
    repeat (n) @(posedge clk);
    check({30'h0, sp_out}, {30'h0, exp});
  endtask
  task automatic go(input int v, input int n, input logic [1:0] exp);
    disp_val <= 18'(v);
    outchk(n, exp);
  endtask
  // momentary press, held long enough for the input synchroniser
  task automatic press(input int which);
    @(posedge clk);
    if (which == 0)
      front_rst_pin <= 1'b1;
    else
      user_rst_pin <= 1'b1;
    repeat (4) @(posedge clk);
    front_rst_pin <= 1'b0;
    user_rst_pin <= 1'b0;
  endtask
  task automatic reset_dut();
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask
  task automatic setup_ch(input logic [7:0] base, input logic [31:0] cfg);
    wr(base, 32'h0000_0064);
    wr(base + 8'h04, 32'h0000_0014);
    wr(base + 8'h08, 32'h0000_0000);
    wr(base + 8'h0C, cfg);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    reset_dut();
    rdchk(SPAO_HYS0_OFF, {16'h0000, SPAO_HYS_RST});
    wr(SPAO_SP0_OFF, 32'h0001_86A0);
    rdchk(SPAO_SP0_OFF, 32'h0001_869F);
    wr(SPAO_HYS0_OFF, 32'h0000_0000);
    rdchk(SPAO_HYS0_OFF, 32'h0000_0001);
    wr(SPAO_HYS0_OFF, 32'h0000_FFFF);
    rdchk(SPAO_HYS0_OFF, 32'h0000_EA5F);
    wr(8'h80, 32'hFFFF_FFFF);
    rdchk(8'h80, 32'h0000_0000);
    $display("test registers done");
    setup_ch(SPAO_SP0_OFF, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      disp_val <= 18'(vals[i][0]);
      wr(SPAO_CFG0_OFF, {30'h0, acts[i]});
      outchk(6, 2'b00);
      for (int j = 1; j < 5; j++)
        go(vals[i][j], 6, {1'b0, exps[j]});
    end
    $display("test actions done");
    wr(SPAO_DLY0_OFF, 32'h0003_0002);
    // low value only starts an on delay that the action change cancels
    disp_val <= 18'sd50;
    wr(SPAO_CFG0_OFF, 32'h0000_0002);
    go(50, 6, 2'b00);
    go(150, 12, 2'b00);
    outchk(13, 2'b01);
    rdchk(SPAO_STAT_OFF, 32'h0000_0005);
    go(50, 25, 2'b01);
    outchk(12, 2'b00);
    go(150, 15, 2'b00);
    go(50, 3, 2'b00);
    go(150, 12, 2'b00);
    outchk(13, 2'b01);
    $display("test delays done");
    wr(SPAO_DLY0_OFF, 32'h0000_0000);
    go(50, 6, 2'b00);
    wr(SPAO_CFG0_OFF, 32'h0000_0042);
    c0 = color_green[0];
    go(150, 6, 2'b01);
    check({31'h0, color_green[0]}, {31'h0, ~c0});
    press(0);
    outchk(6, 2'b00);
    check({31'h0, color_green[0]}, {31'h0, c0});
    outchk(10, 2'b00);
    go(50, 6, 2'b00);
    go(150, 6, 2'b01);
    go(50, 6, 2'b00);
    wr(SPAO_CFG0_OFF, 32'h0000_0006);
    go(150, 6, 2'b01);
    go(50, 6, 2'b01);
    press(1);
    outchk(6, 2'b00);
    go(150, 6, 2'b01);
    wr(SPAO_CTRL_OFF, 32'h0000_0002);
    outchk(6, 2'b00);
    go(50, 6, 2'b00);
    wr(SPAO_CFG0_OFF, 32'h0000_000A);
    go(150, 6, 2'b01);
    press(0);
    outchk(6, 2'b01);
    go(50, 6, 2'b00);
    go(150, 6, 2'b01);
    go(50, 6, 2'b01);
    $display("test reset modes done");
    setup_ch(SPAO_SP0_OFF + SPAO_CH_STRIDE, 32'h0000_0002);
    go(150, 6, 2'b01);
    wr(SPAO_CTRL_OFF, 32'h0000_0001);
    outchk(6, 2'b11);
    check({30'h0, load_on}, 32'h0000_0003);
    usable <= 2'd1;
    outchk(8, 2'b01);
    fitted <= 1'b0;
    outchk(8, 2'b00);
    $display("test outputs done");
    fitted <= 1'b1;
    usable <= 2'd2;
    disp_val <= -18'sd50;
    reset_dut();
    outchk(6, 2'b00);
    fitted <= 1'b0;
    disp_val <= 18'sd99999;
    reset_dut();
    wr(SPAO_CFG0_OFF, 32'h0000_0022);
    setup_ch(SPAO_SP0_OFF, 32'h0000_0022);
    fitted <= 1'b1;
    outchk(10, 2'b00);
    go(50, 6, 2'b00);
    go(150, 6, 2'b01);
    $display("test standby done");
    finish_test();
  end
endmodule
